// ==== rtl/pms_mode_seq.sv ====
// mode selection, rail sequencing, system reset, ship mode and watchdog of the power manager
// assumes analog comparators and key/mode pins are asynchronous; register port comes from the serial slave
`timescale 1ns/100ps
`default_nettype none
`include "pms_regs.svh"
module pms_mode_seq
  import pms_pkg::*;
#(
  parameter int KEY_FILTER_CYC = `PMS_KEY_FILTER_CYC,
  parameter int MS_TICK_CYC = `PMS_MS_TICK_CYC,
  parameter int LONG_STEP_MS = `PMS_LONG_STEP_MS,
  parameter int WD_MS1 = `PMS_WD_MS1,
  parameter int WD_MS2 = `PMS_WD_MS2,
  parameter int WD_MS3 = `PMS_WD_MS3,
  parameter logic [7:0] PWRUP_ORDER = `PMS_ORDER_RST
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire pms_pins_t pins,
  input wire pms_regreq_t regReq,
  input wire logic sysRstIn,
  output logic sysRstOut,
  output logic sysRstOe_n,
  output logic [3:0] railEnable,
  output logic [3:0] railDischarge,
  output logic [1:0] activeMode,
  output logic chargeEnable,
  output logic irqOut,
  output logic inShip,
  output logic [7:0] rdData,
  output logic rdValid
);
  pms_st_t ctlReg;
  pms_st_t ctlNext;
  logic tick;
  logic keyFall;
  logic keyShort;
  logic keyLong;
  logic [7:0] cfg;
  logic [1:0] reqMode;
  logic [3:0] railBad;
  logic [1:0] seqRail;
  logic [15:0] longLimit;
  logic [15:0] wdLimit;
  logic wdExp;
  logic modeGo;
  logic chgAttach;
  logic seqBusy;
  logic wdRestart;

  // a mode register is any of the four consecutive slots
  function automatic logic isModeCfg(input logic [7:0] a);
    isModeCfg = (a >= `PMS_MODECFG_ADDR) && (a < `PMS_MODECFG_ADDR + 8'h04);
  endfunction

  function automatic pms_st_t regDefaults(input pms_st_t s);
    pms_st_t d;
    d = s;
    d.modeCfg = {4{`PMS_MODECFG_RST}};
    d.ctrl = `PMS_CTRL_RST;
    d.wdClr = 8'h00;
    d.disch = `PMS_DISCH_RST;
    d.irqMask = 2'h0;
    d.mode = 2'h0;
    return d;
  endfunction

  assign sysRstOut = ctlReg.rstOut;
  assign sysRstOe_n = ctlReg.rstOeN;
  assign railEnable = ctlReg.railEn;
  assign railDischarge = ctlReg.discharge;
  assign activeMode = ctlReg.mode;
  assign chargeEnable = ctlReg.chargeEn;
  assign irqOut = ctlReg.irqOut;
  assign inShip = ctlReg.shipOut;
  assign rdData = ctlReg.rdData;
  assign rdValid = ctlReg.rdValid;

  always_comb begin
    ctlNext = ctlReg;
    ctlNext.s1 = pins;
    ctlNext.s2 = ctlReg.s1;
    ctlNext.rdValid = 1'b0;
    keyFall = 1'b0;
    keyShort = 1'b0;
    keyLong = 1'b0;
    wdExp = 1'b0;
    modeGo = 1'b0;
    wdRestart = 1'b0;
    cfg = ctlReg.modeCfg[ctlReg.mode];
    seqRail = PWRUP_ORDER[{ctlReg.step, 1'b0} +: 2];
    chgAttach = ctlReg.s2.chargerInputSupply & ~ctlReg.chgPrev;
    ctlNext.chgPrev = ctlReg.s2.chargerInputSupply;
    tick = (ctlReg.tickCnt == 16'(MS_TICK_CYC - 1));
    ctlNext.tickCnt = tick ? 16'h0000 : ctlReg.tickCnt + 16'h0001;
    // widen before adding one, so the longest setting cannot wrap to zero
    longLimit = 16'(LONG_STEP_MS) * ({14'h0000, ctlReg.ctrl[`PMS_CTRL_LONG_LSB +: 2]} + 16'h0001);

    // key filter: a fall counts only after staying low the whole filter time
    if (ctlReg.s2.powerKeyN) begin
      keyShort = ctlReg.keyDone & ~ctlReg.longDone;
      ctlNext.keyCnt = 16'h0000;
      ctlNext.keyDone = 1'b0;
      ctlNext.longDone = 1'b0;
      ctlNext.pressMs = 16'h0000;
    end else if (!ctlReg.keyDone) begin
      ctlNext.keyCnt = ctlReg.keyCnt + 16'h0001;
      if (ctlReg.keyCnt == 16'(KEY_FILTER_CYC - 1)) begin
        ctlNext.keyDone = 1'b1;
        keyFall = 1'b1;
      end
    end else if (tick && !ctlReg.longDone) begin
      ctlNext.pressMs = ctlReg.pressMs + 16'h0001;
      if (ctlReg.pressMs + 16'h0001 >= longLimit) begin
        ctlNext.longDone = 1'b1;
        keyLong = 1'b1;
      end
    end

    // register writes come first so that hardware events below win over a clear
    if (regReq.wrEn) begin
      if (regReq.addr == `PMS_WDCLR_ADDR) begin
        ctlNext.wdClr = regReq.wrData;
        if (regReq.wrData[2:0] == `PMS_WDCLR_CODE) begin
          wdRestart = 1'b1;
          ctlNext.chgSusp = 1'b0;
        end
      end else if (regReq.addr == `PMS_CTRL_ADDR) begin
        ctlNext.ctrl = regReq.wrData;
      end else if (isModeCfg(regReq.addr)) begin
        ctlNext.modeCfg[regReq.addr[1:0] - 2'h2] = regReq.wrData;
      end else if (regReq.addr == `PMS_DISCH_ADDR) begin
        ctlNext.disch = regReq.wrData[3:0];
      end else if (regReq.addr == `PMS_IRQMASK_ADDR) begin
        ctlNext.irqMask = regReq.wrData[1:0];
      end else if (regReq.addr == `PMS_IRQFLAG_ADDR) begin
        ctlNext.irqFlags = ctlReg.irqFlags & ~regReq.wrData[1:0];
      end
    end
    if (regReq.rdEn) begin
      ctlNext.rdValid = 1'b1;
      if (regReq.addr == `PMS_WDCLR_ADDR) begin
        ctlNext.rdData = ctlReg.wdClr;
      end else if (regReq.addr == `PMS_PGSTAT_ADDR) begin
        ctlNext.rdData = {4'h0, ctlReg.pgStat};
      end else if (regReq.addr == `PMS_CTRL_ADDR) begin
        ctlNext.rdData = ctlReg.ctrl;
      end else if (isModeCfg(regReq.addr)) begin
        ctlNext.rdData = ctlReg.modeCfg[regReq.addr[1:0] - 2'h2];
      end else if (regReq.addr == `PMS_DISCH_ADDR) begin
        ctlNext.rdData = {4'h0, ctlReg.disch};
      end else if (regReq.addr == `PMS_IRQMASK_ADDR) begin
        ctlNext.rdData = {6'h00, ctlReg.irqMask};
      end else if (regReq.addr == `PMS_IRQFLAG_ADDR) begin
        ctlNext.rdData = {6'h00, ctlReg.irqFlags};
      end else begin
        ctlNext.rdData = 8'h00;
      end
    end

    // pin path and bus path never mix: the live mode's own bit picks one
    reqMode = cfg[`PMS_CFG_PINSEL] ? {ctlReg.s2.modePinHigh, ctlReg.s2.modePinLow}
                                   : ctlReg.ctrl[1:0];

    // watchdog counts ms ticks only while the live mode enables it
    case (cfg[`PMS_CFG_WDSEL_LSB +: 2])
      2'h1: wdLimit = 16'(WD_MS1);
      2'h2: wdLimit = 16'(WD_MS2);
      2'h3: wdLimit = 16'(WD_MS3);
      default: wdLimit = 16'h0000;
    endcase
    if (ctlReg.state != ST_ON || wdLimit == 16'h0000 || wdRestart) begin
      ctlNext.wdMs = 16'h0000;
    end else if (ctlReg.wdMs >= wdLimit) begin
      wdExp = 1'b1;
    end else if (tick) begin
      ctlNext.wdMs = ctlReg.wdMs + 16'h0001;
    end
    if (tick && ctlReg.wdHold) begin
      ctlNext.wdHold = 1'b0;
    end

    case (ctlReg.state)
      ST_UNPOW: begin
        if (ctlReg.s2.chargerInputSupply || ctlReg.s2.systemNodeAboveUvlo) begin
          ctlNext.state = ST_PWRUP;
          ctlNext.step = 2'h0;
        end
      end
      ST_PWRUP: begin
        ctlNext.railEn[seqRail] = cfg[seqRail];
        if (!cfg[seqRail] || ctlReg.s2.railAbove90[seqRail]) begin
          ctlNext.step = ctlReg.step + 2'h1;
          if (ctlReg.step == 2'h3) begin
            ctlNext.state = ST_ON;
          end
        end
      end
      ST_ON: begin
        if (cfg[`PMS_CFG_SHIP]) begin
          ctlNext.state = ST_PWRDN;
          ctlNext.shipGo = 1'b1;
          ctlNext.step = 2'h3;
        end else if (ctlReg.ctrl[`PMS_CTRL_PWRDN]) begin
          ctlNext.ctrl[`PMS_CTRL_PWRDN] = 1'b0;
          ctlNext.state = ST_PWRDN;
          ctlNext.step = 2'h3;
        end else if (keyLong) begin
          ctlNext.state = ST_PWRDN;
          ctlNext.cycleGo = 1'b1;
          ctlNext.step = 2'h3;
        end else if (wdExp) begin
          ctlNext.irqFlags[0] = 1'b1;
          ctlNext.wdHold = 1'b1;
          ctlNext.chgSusp = ctlReg.ctrl[`PMS_CTRL_CHGINH];
          ctlNext.ctrl[1:0] = 2'h0;
          ctlNext.mode = 2'h0;
          ctlNext.wdMs = 16'h0000;
          ctlNext.railEn = ctlReg.railEn | ctlReg.modeCfg[0][3:0];
          ctlNext.rampMask = ctlReg.modeCfg[0][3:0] & ~ctlReg.railEn;
          ctlNext.state = ST_MSWUP;
        end else if (reqMode != ctlReg.mode) begin
          modeGo = 1'b1;
          ctlNext.mode = reqMode;
          ctlNext.wdMs = 16'h0000;
          ctlNext.railEn = ctlReg.railEn | ctlReg.modeCfg[reqMode][3:0];
          ctlNext.rampMask = ctlReg.modeCfg[reqMode][3:0] & ~ctlReg.railEn;
          ctlNext.state = ST_MSWUP;
        end
        if (keyFall) begin
          ctlNext.modeCfg[0][`PMS_CFG_PINSEL] = 1'b0;
        end
      end
      ST_MSWUP: begin
        // new mode requests stay pending here and are taken back in ST_ON
        if ((ctlReg.rampMask & ~ctlReg.s2.railAbove90) == 4'h0) begin
          ctlNext.railEn = cfg[3:0];
          ctlNext.rampMask = 4'h0;
          ctlNext.state = ST_ON;
        end
      end
      ST_PWRDN: begin
        ctlNext.railEn[seqRail] = 1'b0;
        if (!ctlReg.s2.railAbove90[seqRail]) begin
          ctlNext.step = ctlReg.step - 2'h1;
          if (ctlReg.step == 2'h0) begin
            ctlNext.step = 2'h0;
            ctlNext.shipGo = 1'b0;
            ctlNext.cycleGo = 1'b0;
            if (ctlReg.shipGo) begin
              ctlNext = regDefaults(ctlNext);
              ctlNext.state = ST_SHIP;
            end else if (ctlReg.cycleGo) begin
              ctlNext = regDefaults(ctlNext);
              ctlNext.state = ST_PWRUP;
            end else begin
              ctlNext.state = ST_WAITKEY;
            end
          end
        end
      end
      ST_SHIP: begin
        if (keyShort) begin
          ctlNext.state = ST_PWRUP;
        end else if (chgAttach) begin
          ctlNext.chgSusp = 1'b0;
          ctlNext.state = ctlReg.ctrl[`PMS_CTRL_EXITSEL] ? ST_WAITKEY : ST_PWRUP;
        end
      end
      ST_WAITKEY: begin
        if (keyFall) begin
          ctlNext.state = ST_PWRUP;
        end
      end
      default: begin
        ctlNext.state = ST_UNPOW;
      end
    endcase

    ctlNext.shipOut = (ctlNext.state == ST_SHIP);
    // a rail still ramping up in a mode switch is not a fault yet
    railBad = ctlReg.railEn & ~ctlReg.rampMask & ~ctlReg.s2.railInTransition
              & (~ctlReg.s2.railAbove90 | ctlReg.s2.railAbove110);
    seqBusy = (ctlReg.state != ST_ON) && (ctlReg.state != ST_MSWUP);
    ctlNext.rstOeN = ~(seqBusy | (|railBad) | ctlReg.wdHold);
    ctlNext.rstOut = 1'b0;

    // steady state watches only the low threshold
    ctlNext.pgStat = (ctlReg.ctrl[`PMS_CTRL_PGEN] && ctlReg.state == ST_ON) ?
                     (ctlReg.railEn & ctlReg.s2.railAbove90 & ~ctlReg.s2.railInTransition) : 4'h0;
    if (ctlNext.pgStat != ctlReg.pgStat) begin
      ctlNext.irqFlags[1] = 1'b1;
    end
    ctlNext.irqOut = |(ctlReg.irqFlags & ctlReg.irqMask);
    ctlNext.discharge = ctlReg.disch & (~ctlReg.railEn | (ctlReg.s2.railInTransition & ctlReg.s2.railStepDown));
    ctlNext.chargeEn = ctlReg.s2.chargerInputSupply & ~ctlReg.chgSusp;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctlReg <= regDefaults('0);
    end else begin
      ctlReg <= ctlNext;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  bus_mode_a: assert property (modeGo && !cfg[`PMS_CFG_PINSEL] |=> ctlReg.mode == $past(ctlReg.ctrl[1:0]))
    else $error("bus mode bits not followed");
  pin_mode_a: assert property (modeGo && cfg[`PMS_CFG_PINSEL]
    |=> ctlReg.mode == $past({ctlReg.s2.modePinHigh, ctlReg.s2.modePinLow}))
    else $error("mode pins not followed");
  rail_fault_a: assert property (|railBad |-> ##1 !sysRstOe_n)
    else $error("reset not asserted on rail fault");
  reset_release_a: assert property (ctlReg.state == ST_ON && railBad == 4'h0 && !ctlReg.wdHold
    |=> sysRstOe_n)
    else $error("reset held without cause");
  seq_reset_a: assert property (ctlReg.state == ST_PWRUP |=> !sysRstOe_n)
    else $error("reset released during power-up");
  wd_expiry_a: assert property (wdExp |=> ctlReg.mode == 2'h0 && ctlReg.irqFlags[0] ##1 !sysRstOe_n)
    else $error("watchdog expiry not acted on");
  up_first_a: assert property (ctlReg.state == ST_MSWUP
    |=> ($past(ctlReg.railEn) & ~ctlReg.railEn) == 4'h0 || $past(ctlReg.rampMask & ~ctlReg.s2.railAbove90) == 4'h0)
    else $error("rail disabled before new rails up");
  ship_entry_a: assert property (ctlReg.state == ST_ON && cfg[`PMS_CFG_SHIP]
    |=> ctlReg.state == ST_PWRDN && ctlReg.shipGo)
    else $error("ship request not taken");
  pin_clear_a: assert property (keyFall && ctlReg.state == ST_ON |=> !ctlReg.modeCfg[0][`PMS_CFG_PINSEL])
    else $error("key fall kept mode 0 pin select");
endmodule
`default_nettype wire

// ==== shared/pms_pkg.sv ====
// types shared by the mode sequencer and its bench
// assumes pms_regs.svh is on the include path
package pms_pkg;
  typedef enum logic [2:0] {ST_UNPOW, ST_PWRUP, ST_ON, ST_MSWUP, ST_PWRDN, ST_SHIP, ST_WAITKEY} pms_state_t;
  typedef struct packed {
    logic chargerInputSupply;
    logic systemNodeAboveUvlo;
    logic powerKeyN;
    logic modePinHigh;
    logic modePinLow;
    logic [3:0] railAbove90;
    logic [3:0] railAbove110;
    logic [3:0] railInTransition;
    logic [3:0] railStepDown;
  } pms_pins_t;
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } pms_regreq_t;
  typedef struct packed {
    pms_state_t state;
    pms_pins_t s1;
    pms_pins_t s2;
    logic [1:0] mode;
    logic [1:0] step;
    logic [3:0] railEn;
    logic [3:0] rampMask;
    logic [3:0][7:0] modeCfg;
    logic [7:0] ctrl;
    logic [7:0] wdClr;
    logic [3:0] disch;
    logic [1:0] irqMask;
    logic [1:0] irqFlags;
    logic [3:0] pgStat;
    logic [15:0] tickCnt;
    logic [15:0] keyCnt;
    logic keyDone;
    logic longDone;
    logic [15:0] pressMs;
    logic [15:0] wdMs;
    logic wdHold;
    logic chgSusp;
    logic chgPrev;
    logic shipGo;
    logic cycleGo;
    logic rstOeN;
    logic rstOut;
    logic [3:0] discharge;
    logic chargeEn;
    logic irqOut;
    logic [7:0] rdData;
    logic rdValid;
    logic shipOut;
  } pms_st_t;
endpackage

// ==== shared/pms_regs.svh ====
// register offsets, field positions, reset values and timing counts of the mode sequencer
// assumes a 40 MHz ref_clk; included by the controller
// Functional notes
// - pin select clear: bus mode bits choose mode
// - pin select set: mode pins choose mode
// - voltage transition starts on switch command
// - mode switch enables new rails before disabling
// - start in mode 0, pin select cleared
// - mode pins decode binary, high pin MSB
// - reset low on enabled rail out of window
// - disabled rails never assert reset
// - reset low until sequenced rails reach 90%
// - watchdog expiry asserts reset when enabled
// - reset released once all causes clear
// - rails in transition do not assert reset
// - ship bit: power down, ship, defaults
// - ship exit on short key or charger
// - charger attach: charge, exit select decides power-up
// - per-mode watchdog duration, expiry raises flag
// - expiry loads mode 0, charge inhibit bit
// - watchdog restarts on clear code or mode change
// - per-mode rail enables, optional active discharge
// - gated power-good status, flag on change
// - filtered key or charger starts power-up
// - factory power-up order, power-down reversed
// - filtered key fall clears mode 0 pin select
// - long key press resets and cycles rails
`ifndef PMS_REGS_SVH
`define PMS_REGS_SVH
`define PMS_WDCLR_ADDR 8'h0d
`define PMS_PGSTAT_ADDR 8'h20
`define PMS_CTRL_ADDR 8'h21
`define PMS_MODECFG_ADDR 8'h22
`define PMS_DISCH_ADDR 8'h26
`define PMS_IRQMASK_ADDR 8'h27
`define PMS_IRQFLAG_ADDR 8'h28
`define PMS_WDCLR_CODE 3'h1
`define PMS_CFG_WDSEL_LSB 4
`define PMS_CFG_PINSEL 6
`define PMS_CFG_SHIP 7
`define PMS_CTRL_EXITSEL 2
`define PMS_CTRL_CHGINH 3
`define PMS_CTRL_PWRDN 4
`define PMS_CTRL_PGEN 5
`define PMS_CTRL_LONG_LSB 6
`define PMS_MODECFG_RST 8'h0f
`define PMS_CTRL_RST 8'h20
`define PMS_DISCH_RST 4'hf
`define PMS_ORDER_RST 8'he4
`define PMS_CLK_KHZ 40000
`define PMS_KEY_FILTER_US 200
`define PMS_KEY_FILTER_CYC ((`PMS_KEY_FILTER_US * `PMS_CLK_KHZ + 999) / 1000)
`define PMS_MS_TICK_CYC `PMS_CLK_KHZ
`define PMS_LONG_STEP_S 4
`define PMS_LONG_STEP_MS (`PMS_LONG_STEP_S * 1000)
`define PMS_WD_MS1 1000
`define PMS_WD_MS2 4000
`define PMS_WD_MS3 16000
`endif

// ==== testbench/pms_rail_model.sv ====
// behavioural rails and system reset line facing the mode sequencer
// assumes fault masks come from the bench at the falling edge
`timescale 1ns/100ps
`default_nettype none
module pms_rail_model #(
  parameter int RISE_CYC = 5
) (
  input wire logic ref_clk,
  input wire logic [3:0] railEnable,
  input wire logic [3:0] dropMask,
  input wire logic [3:0] overMask,
  input wire logic sysRstOe_n,
  output logic [3:0] railAbove90,
  output logic [3:0] railAbove110,
  output logic sysRstLine
);
  int cnt [4];
  // open drain: the pull-up wins whenever nobody pulls low
  assign sysRstLine = sysRstOe_n ? 1'b1 : 1'b0;
  initial begin
    railAbove90 = '0;
    railAbove110 = '0;
    foreach (cnt[i]) cnt[i] = 0;
  end
  // slow ramp so ordering is visible; a disabled rail collapses at once
  always @(negedge ref_clk) begin
    for (int i = 0; i < 4; i++) begin
      cnt[i] = !railEnable[i] ? 0 : (cnt[i] < RISE_CYC) ? cnt[i] + 1 : cnt[i];
      railAbove90[i] = (cnt[i] == RISE_CYC) && !dropMask[i];
      railAbove110[i] = (cnt[i] == RISE_CYC) && overMask[i];
    end
  end
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking bench of the mode sequencer with a behavioural rail model
// assumes shortened key, tick, long press and watchdog parameters
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pms_pkg::*;
  localparam int KEY_CYC = 4;
  logic refClk = 1'b0;
  logic rst = 1'b1;
  pms_pins_t pins;
  pms_regreq_t regReq = '0;
  logic charger = 1'b0, uvloOk = 1'b0, keyN = 1'b1, pinHi = 1'b0, pinLo = 1'b0;
  logic [3:0] dropMask = '0, overMask = '0, transMask = '0, above90, above110, railEnable, railDischarge;
  logic sysRstOut, sysRstOe_n, sysRstLine, chargeEnable, irqOut, inShip, rdValid;
  logic [1:0] activeMode;
  logic [7:0] rdData, rdBuf;
  int failures = 0, checked = 0, cycles = 0;

  // step-down flags tied low: the model ramps upward only
  always_comb pins = {charger, uvloOk, keyN, pinHi, pinLo, above90, above110, transMask, 4'h0};
  always #12.5 refClk = ~refClk;

  pms_mode_seq #(.KEY_FILTER_CYC(KEY_CYC), .MS_TICK_CYC(8), .LONG_STEP_MS(2), .WD_MS1(2), .WD_MS2(3),
    .WD_MS3(4)) u_pms_mode_seq (.ref_clk(refClk), .rst(rst), .pins(pins), .regReq(regReq),
    .sysRstIn(sysRstLine), .sysRstOut(sysRstOut), .sysRstOe_n(sysRstOe_n), .railEnable(railEnable),
    .railDischarge(railDischarge), .activeMode(activeMode), .chargeEnable(chargeEnable), .irqOut(irqOut),
    .inShip(inShip), .rdData(rdData), .rdValid(rdValid));
  pms_rail_model u_pms_rail_model (.ref_clk(refClk), .railEnable(railEnable), .dropMask(dropMask),
    .overMask(overMask), .sysRstOe_n(sysRstOe_n), .railAbove90(above90), .railAbove110(above110),
    .sysRstLine(sysRstLine));

  task automatic complete_run();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge refClk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("Error at %0t: run hung", $time);
      complete_run();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [7:0] cur(input int sel);
    case (sel)
      0: return {7'h0, sysRstOe_n};
      1: return {6'h0, activeMode};
      2: return {7'h0, inShip};
      default: return {4'h0, railEnable};
    endcase
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge refClk);
  endtask

  // bounded wait, so a stuck output shows as a mismatch, not a hang
  task automatic waitVal(input int sel, input logic [7:0] exp, input int lim, input string what);
    int n;
    n = 0;
    while (cur(sel) !== exp && n < lim) begin
      @(negedge refClk);
      n++;
    end
    chk(cur(sel), exp, what);
  endtask

  task automatic regWr(input logic [7:0] a, input logic [7:0] d);
    regReq.wrEn = 1'b1;
    regReq.addr = a;
    regReq.wrData = d;
    cyc(1);
    regReq.wrEn = 1'b0;
    cyc(1);
  endtask

  task automatic regRd(input logic [7:0] a, output logic [7:0] d);
    regReq.rdEn = 1'b1;
    regReq.addr = a;
    cyc(1);
    d = rdData;
    chk(8'(rdValid), 8'h01, "read valid");
    regReq.rdEn = 1'b0;
    cyc(1);
  endtask

  task automatic t_powerup();
    uvloOk = 1'b1;
    waitVal(3, 8'h01, 40, "first rail up");
    chk(cur(0), 8'h00, "reset while ramping");
    chk({7'h0, sysRstOut}, 8'h00, "reset level low");
    waitVal(0, 8'h01, 100, "reset released");
    chk(cur(3), 8'h0f, "rails on");
    chk(cur(1), 8'h00, "start mode");
    regRd(8'h22, rdBuf);
    chk(rdBuf, 8'h0f, "mode cfg default");
    regRd(8'h20, rdBuf);
    chk(rdBuf, 8'h0f, "power good");
    regWr(8'h20, 8'h00);
    regRd(8'h20, rdBuf);
    chk(rdBuf, 8'h0f, "status read only");
    regRd(8'h30, rdBuf);
    chk(rdBuf, 8'h00, "unmapped read");
    $display("test powerup done");
  endtask

  task automatic t_bus_mode();
    regWr(8'h23, 8'h03);
    regWr(8'h24, 8'h0c);
    pinHi = 1'b1;
    pinLo = 1'b1;
    regWr(8'h21, 8'h21);
    waitVal(1, 8'h01, 10, "bus picks mode 1");
    waitVal(3, 8'h03, 10, "mode 1 rails");
    cyc(10);
    chk(cur(0), 8'h01, "disabled rails ignored");
    chk({4'h0, railDischarge}, 8'h0c, "discharge on off rails");
    regWr(8'h21, 8'h22);
    waitVal(1, 8'h02, 10, "bus picks mode 2");
    chk(cur(3), 8'h0f, "new rails before old off");
    waitVal(3, 8'h0c, 20, "old rails off");
    chk(cur(0), 8'h01, "no reset in switch");
    $display("test bus mode done");
  endtask

  task automatic t_pin_mode();
    regWr(8'h21, 8'he2);
    regWr(8'h22, 8'h4f);
    regWr(8'h23, 8'h4f);
    regWr(8'h25, 8'h4f);
    regWr(8'h24, 8'h4f);
    for (int i = 0; i < 4; i++) begin
      {pinHi, pinLo} = 2'(i);
      waitVal(1, 8'(i), 30, "pin decode");
    end
    regWr(8'h21, 8'he0);
    cyc(6);
    chk(cur(1), 8'h03, "bus bits ignored");
    {pinHi, pinLo} = 2'h0;
    waitVal(1, 8'h00, 30, "pins back to 0");
    keyN = 1'b0;
    cyc(KEY_CYC + 6);
    keyN = 1'b1;
    cyc(4);
    regRd(8'h22, rdBuf);
    chk(rdBuf, 8'h0f, "key clears pin select");
    $display("test pin mode done");
  endtask

  task automatic t_fault();
    waitVal(0, 8'h01, 30, "settled");
    dropMask = 4'h2;
    waitVal(0, 8'h00, 8, "undervolt");
    dropMask = 4'h0;
    waitVal(0, 8'h01, 8, "undervolt cleared");
    overMask = 4'h4;
    waitVal(0, 8'h00, 8, "overvolt");
    overMask = 4'h0;
    waitVal(0, 8'h01, 8, "overvolt cleared");
    transMask = 4'h8;
    dropMask = 4'h8;
    cyc(8);
    chk(cur(0), 8'h01, "ramping rail ignored");
    dropMask = 4'h0;
    cyc(4);
    transMask = 4'h0;
    cyc(4);
    chk(cur(0), 8'h01, "transition ended clean");
    $display("test fault done");
  endtask

  task automatic t_watchdog();
    regWr(8'h27, 8'h01);
    regWr(8'h21, 8'h28);
    regWr(8'h22, 8'h1f);
    // one tick per clear period keeps the count below expiry
    repeat (6) begin
      cyc(6);
      regWr(8'h0d, 8'h01);
    end
    chk(cur(0), 8'h01, "watchdog held off");
    waitVal(0, 8'h00, 40, "expiry reset");
    regWr(8'h22, 8'h0f);
    regRd(8'h28, rdBuf);
    chk(rdBuf & 8'h01, 8'h01, "expiry flag");
    chk(cur(1), 8'h00, "mode 0 after expiry");
    chk({7'h0, irqOut}, 8'h01, "expiry irq");
    charger = 1'b1;
    cyc(4);
    chk({7'h0, chargeEnable}, 8'h00, "charge suspended");
    regWr(8'h0d, 8'h01);
    chk({7'h0, chargeEnable}, 8'h01, "charge resumed");
    charger = 1'b0;
    waitVal(0, 8'h01, 40, "expiry reset released");
    regWr(8'h28, 8'h03);
    regRd(8'h28, rdBuf);
    chk(rdBuf & 8'h01, 8'h00, "flag cleared");
    chk({7'h0, irqOut}, 8'h00, "irq cleared");
    $display("test watchdog done");
  endtask

  task automatic t_ship();
    regWr(8'h22, 8'h8f);
    waitVal(3, 8'h07, 10, "last up first down");
    waitVal(2, 8'h01, 100, "ship entered");
    regRd(8'h21, rdBuf);
    chk(rdBuf, 8'h20, "ctrl default");
    charger = 1'b1;
    waitVal(0, 8'h01, 150, "charger exit");
    chk({7'h0, chargeEnable}, 8'h01, "charging on");
    charger = 1'b0;
    regWr(8'h22, 8'h8f);
    waitVal(2, 8'h01, 100, "ship again");
    keyN = 1'b0;
    cyc(KEY_CYC + 6);
    keyN = 1'b1;
    waitVal(0, 8'h01, 150, "key exit");
    chk(cur(3), 8'h0f, "rails back");
    $display("test ship done");
  endtask

  task automatic t_long_press();
    regWr(8'h26, 8'h05);
    keyN = 1'b0;
    waitVal(3, 8'h00, 80, "long press powers down");
    keyN = 1'b1;
    waitVal(0, 8'h01, 150, "long press powers up");
    chk(cur(3), 8'h0f, "rails cycled");
    regRd(8'h26, rdBuf);
    chk(rdBuf, 8'h0f, "defaults after long press");
    $display("test long press done");
  endtask

  initial begin
    cyc(12);
    rst = 1'b0;
    cyc(2);
    t_powerup();
    t_bus_mode();
    t_pin_mode();
    t_fault();
    t_watchdog();
    t_ship();
    t_long_press();
    complete_run();
  end
endmodule
`default_nettype wire
